/* src/video_capture_window_timing.v */
// Purpose: capture window timing, serial configuration and pixel capture
// Assumes: digitized rgb arrives on i_mclk; serial link pins are asynchronous
// Notes: pixel rate is a one-cycle enable from a phase accumulator
//
// Contract
// - PAL or NTSC choice comes from a serial link command, sent before capture.
// - Host programs the captured rectangle; only pixels inside it are captured.
// - Only the selected region goes out in rgb to both converters.
// - PAL: 14.7 MHz pixels, line total 944, start 152, active 768.
// - NTSC: 12.272725 MHz pixels, line total 780, start 118, active 640.
// - NTSC: field active from line 17, frame 525 lines, 29.97 Hz.
// - Video converter returns a feedback signal to the capture logic.
`timescale 1ns/1ps
`include "video_capture_consts.vh"

// ****************************************
// small fifo with registered output
// ****************************************
module capture_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output reg o_out_valid,
    input wire i_out_ready,
    output reg [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    // honest full and empty
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign push = i_in_valid && o_in_ready;
    assign pop = (count != {(AW+1){1'b0}}) && (!o_out_valid || i_out_ready);
    // storage, pointers and output stage
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            o_out_valid <= 1'b0;
            o_out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= i_in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                o_out_data <= mem[rd_ptr];
                rd_ptr <= rd_ptr + 1'b1;
                o_out_valid <= 1'b1;
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // capture_fifo

// ****************************************
// top: timing, configuration, capture
// ****************************************
module video_capture_window_timing #(
    parameter RGB_W = 24,
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2,
    parameter [6:0] DEV_ADDR = `DEV_ADDR
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_scl,
    input wire i_sda,
    output reg o_sda_out,
    output reg o_sda_oe,
    input wire [RGB_W-1:0] i_rgb,
    input wire i_cvid_feedback,
    input wire i_cvid_ready,
    input wire i_prn_ready,
    output wire [RGB_W-1:0] o_rgb,
    output wire o_rgb_valid,
    output reg o_line_active,
    output reg o_field,
    output reg o_frame_start,
    output reg o_ntsc_mode,
    output reg o_converter_locked,
    output reg o_overrun
);
    localparam [63:0] PAL_INC = (`PAL_PIX_HZ << `PHASE_BITS) / `SYS_CLK_HZ;
    localparam [63:0] NTSC_INC = (`NTSC_PIX_HZ << `PHASE_BITS) / `SYS_CLK_HZ;
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_ACK_A = 3'h2;
    localparam [2:0] S_PTR = 3'h3;
    localparam [2:0] S_ACK_P = 3'h4;
    localparam [2:0] S_DATA = 3'h5;
    localparam [2:0] S_ACK_D = 3'h6;

    // ****************************************
    // pin synchronisers, three stages
    // ****************************************
    reg [2:0] scl_sync;
    reg [2:0] sda_sync;
    reg [2:0] fb_sync;
    reg scl_q;
    reg sda_q;
    reg scl_d;
    reg sda_d;
    // a change counts once stages two and three agree
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            fb_sync <= 3'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            o_converter_locked <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[1:0], i_scl};
            sda_sync <= {sda_sync[1:0], i_sda};
            fb_sync <= {fb_sync[1:0], i_cvid_feedback};
            if (scl_sync[2] == scl_sync[1]) scl_q <= scl_sync[2];
            if (sda_sync[2] == sda_sync[1]) sda_q <= sda_sync[2];
            if (fb_sync[2] == fb_sync[1]) o_converter_locked <= fb_sync[2];
            scl_d <= scl_q;
            sda_d <= sda_q;
        end
    end
    wire scl_rise = scl_q && !scl_d;
    wire scl_fall = !scl_q && scl_d;
    wire bus_start = scl_q && scl_d && sda_d && !sda_q;
    wire bus_stop = scl_q && scl_d && !sda_d && sda_q;

    // ****************************************
    // serial configuration slave, write only
    // ****************************************
    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shreg;
    reg [3:0] ptr;
    reg [7:0] cfg [0:`CFG_REGS-1];
    integer k;
    // link driven by the bridge; commands stored here
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 4'h0;
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
            for (k = 0; k < `CFG_REGS; k = k + 1) begin
                cfg[k] <= `CFG_RESET_VAL;
            end
            cfg[`CFG_W_LO] <= `CFG_SIZE_RESET;
            cfg[`CFG_W_HI] <= `CFG_SIZE_RESET;
            cfg[`CFG_H_LO] <= `CFG_SIZE_RESET;
            cfg[`CFG_H_HI] <= `CFG_SIZE_RESET;
        end else if (bus_stop) begin
            state <= S_IDLE;
            o_sda_oe <= 1'b0;
        end else if (bus_start) begin
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            o_sda_oe <= 1'b0;
        end else if (scl_rise && (state == S_ADDR || state == S_PTR || state == S_DATA)) begin
            shreg <= {shreg[6:0], sda_q};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall) begin
            case (state)
                S_ADDR: begin
                    if (bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (shreg[7:1] == DEV_ADDR && !shreg[0]) begin
                            o_sda_oe <= 1'b1;
                            state <= S_ACK_A;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_PTR: begin
                    if (bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        ptr <= shreg[3:0];
                        o_sda_oe <= 1'b1;
                        state <= S_ACK_P;
                    end
                end
                S_DATA: begin
                    if (bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (ptr < `CFG_REGS) cfg[ptr] <= shreg;
                        ptr <= ptr + 4'h1;
                        o_sda_oe <= 1'b1;
                        state <= S_ACK_D;
                    end
                end
                S_ACK_A: begin
                    o_sda_oe <= 1'b0;
                    state <= S_PTR;
                end
                S_ACK_P, S_ACK_D: begin
                    o_sda_oe <= 1'b0;
                    state <= S_DATA;
                end
                default: begin
                    o_sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // live settings, taken at frame start
    // ****************************************
    reg cap_en;
    reg [9:0] x_start;
    reg [9:0] x_width;
    reg [9:0] y_start;
    reg [9:0] y_height;
    reg [9:0] line_total;
    reg [9:0] line_start;
    reg [9:0] line_active;
    reg [9:0] field_start;
    reg [9:0] frame_total;
    reg [31:0] phase;
    reg pix_en;
    reg [9:0] hcnt;
    reg [9:0] vcnt;
    wire [9:0] half_frame = (frame_total + 10'h001) >> 1;
    wire line_end = (hcnt == line_total - 10'h001);
    wire frame_end = line_end && (vcnt == frame_total - 10'h001);
    wire [9:0] field_line = o_field ? (vcnt - half_frame) : vcnt;
    wire [9:0] hx = hcnt - line_start;
    wire [9:0] vy = field_line - field_start;
    wire in_line = (hcnt >= line_start) && (hx < line_active);
    wire in_field = (field_line >= field_start);
    // rectangle compare within the active region
    wire in_rect = in_line && in_field && (hx >= x_start) && (hx - x_start < x_width)
        && (vy >= y_start) && (vy - y_start < y_height);
    // pixel rate enable from a phase accumulator
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            phase <= 32'h0000_0000;
            pix_en <= 1'b0;
        end else if (o_ntsc_mode) begin
            {pix_en, phase} <= {1'b0, phase} + {1'b0, NTSC_INC[31:0]};
        end else begin
            {pix_en, phase} <= {1'b0, phase} + {1'b0, PAL_INC[31:0]};
        end
    end
    // line and frame counters, settings reload at frame end
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            hcnt <= 10'h000;
            vcnt <= 10'h000;
            o_field <= 1'b0;
            o_frame_start <= 1'b0;
            o_line_active <= 1'b0;
            o_ntsc_mode <= 1'b0;
            cap_en <= 1'b0;
            x_start <= 10'h000;
            x_width <= 10'h3ff;
            y_start <= 10'h000;
            y_height <= 10'h3ff;
            line_total <= `PAL_LINE_TOTAL;
            line_start <= `PAL_LINE_START;
            line_active <= `PAL_LINE_ACTIVE;
            field_start <= `PAL_FIELD_START;
            frame_total <= `PAL_FRAME_TOTAL;
        end else begin
            o_frame_start <= 1'b0;
            if (pix_en) begin
                o_line_active <= in_line && in_field;
                hcnt <= line_end ? 10'h000 : hcnt + 10'h001;
                if (line_end) vcnt <= frame_end ? 10'h000 : vcnt + 10'h001;
                if (line_end && vcnt == half_frame - 10'h001) o_field <= 1'b1;
                if (frame_end) begin
                    o_field <= 1'b0;
                    o_frame_start <= 1'b1;
                    // standard taken from the link command
                    o_ntsc_mode <= cfg[`CFG_MODE][`MODE_NTSC_BIT];
                    cap_en <= cfg[`CFG_MODE][`MODE_CAPTURE_BIT];
                    x_start <= {cfg[`CFG_X_HI][1:0], cfg[`CFG_X_LO]};
                    x_width <= {cfg[`CFG_W_HI][1:0], cfg[`CFG_W_LO]};
                    y_start <= {cfg[`CFG_Y_HI][1:0], cfg[`CFG_Y_LO]};
                    y_height <= {cfg[`CFG_H_HI][1:0], cfg[`CFG_H_LO]};
                    if (cfg[`CFG_MODE][`MODE_NTSC_BIT]) begin
                        line_total <= `NTSC_LINE_TOTAL;
                        line_start <= `NTSC_LINE_START;
                        line_active <= `NTSC_LINE_ACTIVE;
                        field_start <= `NTSC_FIELD_START;
                        frame_total <= `NTSC_FRAME_TOTAL;
                    end else begin
                        line_total <= `PAL_LINE_TOTAL;
                        line_start <= `PAL_LINE_START;
                        line_active <= `PAL_LINE_ACTIVE;
                        field_start <= `PAL_FIELD_START;
                        frame_total <= `PAL_FRAME_TOTAL;
                    end
                end
            end
        end
    end

    // ****************************************
    // pixel capture into the fifo
    // ****************************************
    reg cap_valid;
    reg [RGB_W-1:0] cap_data;
    wire fifo_ready;
    // only window pixels, once the converter reports lock
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cap_valid <= 1'b0;
            cap_data <= {RGB_W{1'b0}};
            o_overrun <= 1'b0;
        end else begin
            cap_valid <= pix_en && in_rect && cap_en && o_converter_locked;
            cap_data <= i_rgb;
            if (o_frame_start) o_overrun <= 1'b0;
            if (cap_valid && !fifo_ready) o_overrun <= 1'b1;
        end
    end
    capture_fifo #(
        .WIDTH(RGB_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(cap_valid),
        .o_in_ready(fifo_ready),
        .i_in_data(cap_data),
        .o_out_valid(o_rgb_valid),
        .i_out_ready(i_cvid_ready && i_prn_ready),
        .o_out_data(o_rgb)
    );
endmodule // video_capture_window_timing

/* shared/video_capture_consts.vh */
// Purpose: shared constants of the capture window timing block
// Assumes: 20 MHz system clock, pixel rate made by a phase accumulator
// Notes: definitions only
`ifndef VIDEO_CAPTURE_CONSTS_VH
`define VIDEO_CAPTURE_CONSTS_VH
// ****************************************
// clock and pixel rates
// ****************************************
`define SYS_CLK_HZ 64'd20000000
`define PAL_PIX_HZ 64'd14700000
`define NTSC_PIX_HZ 64'd12272725
`define PHASE_BITS 32
// ****************************************
// line and frame geometry
// ****************************************
`define PAL_LINE_TOTAL 10'h3b0
`define PAL_LINE_START 10'h098
`define PAL_LINE_ACTIVE 10'h300
`define PAL_FIELD_START 10'h035
`define PAL_FRAME_TOTAL 10'h271
`define NTSC_LINE_TOTAL 10'h30c
`define NTSC_LINE_START 10'h076
`define NTSC_LINE_ACTIVE 10'h280
`define NTSC_FIELD_START 10'h011
`define NTSC_FRAME_TOTAL 10'h20d
// ****************************************
// configuration map over the serial link
// ****************************************
`define CFG_REGS 9
`define CFG_MODE 4'h0
`define CFG_X_LO 4'h1
`define CFG_X_HI 4'h2
`define CFG_W_LO 4'h3
`define CFG_W_HI 4'h4
`define CFG_Y_LO 4'h5
`define CFG_Y_HI 4'h6
`define CFG_H_LO 4'h7
`define CFG_H_HI 4'h8
`define MODE_NTSC_BIT 0
`define MODE_CAPTURE_BIT 1
`define CFG_RESET_VAL 8'h00
`define CFG_SIZE_RESET 8'hff
`define DEV_ADDR 7'h2a
`endif

/* testbench/capture_window_monitor.sv */
// Purpose: port checks of the capture window timing block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
// ****************************************
// checker
// ****************************************
module capture_window_monitor #(
    parameter RGB_W = 24
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire i_scl,
    input wire i_sda,
    input wire o_sda_out,
    input wire o_sda_oe,
    input wire [RGB_W-1:0] i_rgb,
    input wire i_cvid_feedback,
    input wire i_cvid_ready,
    input wire i_prn_ready,
    input wire [RGB_W-1:0] o_rgb,
    input wire o_rgb_valid,
    input wire o_line_active,
    input wire o_field,
    input wire o_frame_start,
    input wire o_ntsc_mode,
    input wire o_converter_locked,
    input wire o_overrun
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    logic [10:0] run;
    logic [16:0] gap;
    // active run length and line start spacing
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            run <= 11'h000;
            gap <= 17'h00000;
        end else begin
            run <= o_line_active ? run + 11'h001 : 11'h000;
            gap <= $rose(o_line_active) ? 17'h00001 : gap + {16'h0000, ~&gap};
        end
    end
    a_sda_pull_only: assert property (o_sda_oe |-> !o_sda_out)
        else $error("sda driven high");
    a_reset_quiet: assert property (disable iff (1'b0) i_sys_rst |=>
        !o_sda_oe && !o_rgb_valid && !o_line_active && !o_frame_start && !o_ntsc_mode)
        else $error("outputs busy in reset");
    a_pulse_once: assert property (o_frame_start |=> !o_frame_start)
        else $error("frame start longer than one cycle");
    a_mode_at_wrap: assert property ($changed(o_ntsc_mode) |->
        o_frame_start || $past(o_frame_start)) else $error("standard changed mid frame");
    a_valid_holds: assert property (o_rgb_valid && !(i_cvid_ready && i_prn_ready) |=>
        o_rgb_valid && $stable(o_rgb)) else $error("pixel dropped while stalled");
    a_active_width: assert property ($fell(o_line_active) |->
        run >= 11'h411 && run <= 11'h417) else $error("active width wrong");
    a_line_period: assert property ($rose(o_line_active) && gap < 17'h007d0 |->
        (o_ntsc_mode ? (gap >= 17'h004f6 && gap <= 17'h004f9)
        : (gap >= 17'h00503 && gap <= 17'h00506))) else $error("line period wrong");
    a_field_quiet: assert property ($changed(o_field) |-> !o_line_active)
        else $error("field changed inside active");
    a_overrun_clear: assert property (o_frame_start |-> ##[1:2] !o_overrun)
        else $error("overrun kept past frame start");
    a_capture_locked: assert property ($rose(o_rgb_valid) |->
        o_converter_locked || $past(o_converter_locked, 3)) else $error("capture unlocked");
endmodule // capture_window_monitor

/* testbench/cfg_link_host.sv */
// Purpose: serial configuration host on the far side of the link
// Assumes: open-drain data, wire level worked out by the bench
// Notes: clock high for 8 system clocks and low for 9, write only
`timescale 1ns/1ps
module cfg_link_host (
    input wire i_mclk,
    input wire i_sda_wire,
    output reg o_scl,
    output reg o_sda_low
);
    // idle: both lines released
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // one bit, data moved only while the clock is low
    task bit_io(input logic b, output logic s);
        o_sda_low = !b;
        repeat (8) @(negedge i_mclk);
        o_scl = 1'b1;
        repeat (8) @(negedge i_mclk);
        s = i_sda_wire;
        o_scl = 1'b0;
        @(negedge i_mclk);
    endtask
    task write_cfg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
        output logic ack);
        logic [23:0] w;
        logic s;
        w = {a, p, d};
        ack = 1'b1;
        o_sda_low = 1'b1;
        repeat (8) @(negedge i_mclk);
        o_scl = 1'b0;
        @(negedge i_mclk);
        for (int i = 23; i >= 0; i--) begin
            bit_io(w[i], s);
            if (i % 8 == 0) begin
                bit_io(1'b1, s);
                ack = ack & !s;
            end
        end
        o_sda_low = 1'b1;
        repeat (8) @(negedge i_mclk);
        o_scl = 1'b1;
        repeat (8) @(negedge i_mclk);
        o_sda_low = 1'b0;
        repeat (8) @(negedge i_mclk);
    endtask
endmodule // cfg_link_host

/* testbench/tb_video_capture_window_timing.sv */
// Purpose: self-checking bench of the capture window timing block
// Assumes: 20 MHz clock, inputs moved on the falling edge
// Notes: run covers the first active lines of the first field
`timescale 1ns/1ps
`include "video_capture_consts.vh"
`define CHECK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb_video_capture_window_timing;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_cvid_feedback = 1'b0;
    logic i_cvid_ready = 1'b1;
    logic i_prn_ready = 1'b1;
    logic [23:0] i_rgb = 24'h000000;
    logic ack;
    wire scl, sda_low, o_sda_out, o_sda_oe, o_rgb_valid, o_line_active, o_field;
    wire o_frame_start, o_ntsc_mode, o_converter_locked, o_overrun;
    wire [23:0] o_rgb;
    wire sda = !(sda_low || o_sda_oe);
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    int m;
    // clock, cycle count from reset release, moving pixels
    always #25 i_mclk = ~i_mclk;
    always @(posedge i_mclk) cyc <= i_sys_rst ? 0 : cyc + 1;
    always @(negedge i_mclk) i_rgb <= i_rgb + 24'h010203;
    video_capture_window_timing dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(scl),
        .i_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_rgb(i_rgb),
        .i_cvid_feedback(i_cvid_feedback), .i_cvid_ready(i_cvid_ready),
        .i_prn_ready(i_prn_ready), .o_rgb(o_rgb), .o_rgb_valid(o_rgb_valid),
        .o_line_active(o_line_active), .o_field(o_field), .o_frame_start(o_frame_start),
        .o_ntsc_mode(o_ntsc_mode), .o_converter_locked(o_converter_locked),
        .o_overrun(o_overrun));
    cfg_link_host host (.i_mclk(i_mclk), .i_sda_wire(sda), .o_scl(scl), .o_sda_low(sda_low));
    // ****************************************
    // scenarios
    // ****************************************
    task t_refused();
        logic [7:0] bad [2];
        bad[0] = {`DEV_ADDR + 7'h01, 1'b0};
        bad[1] = {`DEV_ADDR, 1'b1};
        for (int i = 0; i < 2; i++) begin
            host.write_cfg(bad[i], {4'h0, `CFG_MODE}, 8'h03, ack);
            `CHECK("bad address ack", 1'b0, ack)
        end
    endtask
    task t_config();
        host.write_cfg({`DEV_ADDR, 1'b0}, {4'h0, `CFG_MODE}, 8'h03, ack);
        `CHECK("mode ack", 1'b1, ack)
        host.write_cfg({`DEV_ADDR, 1'b0}, {4'h0, `CFG_X_LO}, 8'h10, ack);
        `CHECK("window ack", 1'b1, ack)
        host.write_cfg({`DEV_ADDR, 1'b0}, 8'h09, 8'h55, ack);
        `CHECK("spare pointer ack", 1'b1, ack)
        `CHECK("standard before wrap", 1'b0, o_ntsc_mode)
    endtask
    task wait_lock(input logic v);
        i_cvid_feedback <= v;
        for (int k = 0; k < 32 && o_converter_locked !== v; k++) @(negedge i_mclk);
        `CHECK("locked", v, o_converter_locked)
    endtask
    task t_timing();
        for (int k = 0; k < 90000 && o_line_active !== 1'b1; k++) @(negedge i_mclk);
        `CHECK("first active", 1'b1, (cyc > 68265 && cyc < 68290))
        `CHECK("first field", 1'b0, o_field)
        `CHECK("no capture yet", 1'b0, o_rgb_valid)
        `CHECK("no overrun", 1'b0, o_overrun)
        `CHECK("rgb idle", 24'h000000, o_rgb)
        `CHECK("no frame wrap", 1'b0, o_frame_start)
        for (n = 0; n < 2000 && o_line_active === 1'b1; n++) @(negedge i_mclk);
        `CHECK("active width", 1'b1, (n >= 1043 && n <= 1047))
        for (m = 0; m < 2000 && o_line_active !== 1'b1; m++) @(negedge i_mclk);
        `CHECK("line period", 1'b1, (n + m >= 1283 && n + m <= 1286))
    endtask
    task results();
        $display("errors %0d of %0d checks", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(negedge i_mclk);
        i_sys_rst <= 1'b0;
        repeat (4) @(negedge i_mclk);
        `CHECK("standard at reset", 1'b0, o_ntsc_mode)
        `CHECK("sda at reset", 1'b0, o_sda_oe)
        `CHECK("sda level", 1'b0, o_sda_out)
        wait_lock(1'b1);
        t_refused();
        t_config();
        wait_lock(1'b0);
        wait_lock(1'b1);
        t_timing();
        results();
    end
    // watchdog
    initial begin
        repeat (95000) @(posedge i_mclk);
        num_errors++;
        results();
    end
endmodule // tb_video_capture_window_timing
bind video_capture_window_timing capture_window_monitor #(.RGB_W(RGB_W)) u_mon (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_rgb(i_rgb),
    .i_cvid_feedback(i_cvid_feedback), .i_cvid_ready(i_cvid_ready),
    .i_prn_ready(i_prn_ready), .o_rgb(o_rgb), .o_rgb_valid(o_rgb_valid),
    .o_line_active(o_line_active), .o_field(o_field), .o_frame_start(o_frame_start),
    .o_ntsc_mode(o_ntsc_mode), .o_converter_locked(o_converter_locked),
    .o_overrun(o_overrun));
